/* File: inc/fault_flag_pkg.sv */
/*
  package for the fault flag and response block: flag positions, register
  offsets, reset values, timing counts and carrier structs.
  assumes a 125 MHz clock and a 32-bit apb slave bus.
*/
package fault_flag_pkg;

  // clock rate in khz, used to derive cycle counts
  localparam int unsigned CLK_KHZ = 125000;

  // interrupt pulse length in microseconds, and in cycles
  localparam int unsigned IRQ_PULSE_US = 128;
  localparam int unsigned IRQ_PULSE_CYC = IRQ_PULSE_US * CLK_KHZ / 1000;

  // push-button hold times in milliseconds (defaults, plain values)
  localparam int unsigned WAKE_ONE_MS = 100;
  localparam int unsigned WAKE_TWO_MS = 1000;
  localparam int unsigned RESET_WARN_MS = 8000;
  localparam int unsigned WAKE_ONE_CYC = WAKE_ONE_MS * CLK_KHZ;
  localparam int unsigned WAKE_TWO_CYC = WAKE_TWO_MS * CLK_KHZ;
  localparam int unsigned RESET_WARN_CYC = RESET_WARN_MS * CLK_KHZ;

  // flag bit positions in the flag, mask and raw status words
  localparam int unsigned FLAG_WIDTH = 15;
  localparam int unsigned B_WARM = 0;
  localparam int unsigned B_HOT = 1;
  localparam int unsigned B_CONV_READY = 2;
  localparam int unsigned B_ALARM_ONE = 3;
  localparam int unsigned B_ALARM_TWO = 4;
  localparam int unsigned B_ALARM_THREE = 5;
  localparam int unsigned B_CEILING = 6;
  localparam int unsigned B_OPEN = 7;
  localparam int unsigned B_WATCHDOG = 8;
  localparam int unsigned B_TIMER_EXP = 9;
  localparam int unsigned B_REG_OCP = 10;
  localparam int unsigned B_PIN_OPEN = 11;
  localparam int unsigned B_WAKE_ONE = 12;
  localparam int unsigned B_WAKE_TWO = 13;
  localparam int unsigned B_RESET_WARN = 14;

  // register byte offsets
  localparam logic [7:0] OFS_FLAG = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0c;

  // reset values
  localparam logic [14:0] MASK_RST = 15'h7fff;
  localparam logic [1:0] CTRL_RST = 2'h1;

  // control register fields
  localparam int unsigned C_REG_EN = 0;
  localparam int unsigned C_TIMER_EN = 1;

  // apb request carrier
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  // charger-side response carrier
  typedef struct packed {
    logic charge_en;
    logic reduce_vreg;
    logic timer_run;
    logic timer_clear;
    logic regulator_en;
    logic rail_en;
  } response_t;

endpackage : fault_flag_pkg

/* File: src/fault_flag_response.sv */
/*
  fault flag and response block: latches events on rising edges, pulses
  an interrupt, drives charger, timer, regulator and rail responses.
  assumes asynchronous status inputs from analog/other logic, apb host.
*/
// Chosen here: the APB interface to the registers and the register addresses.
// Summary of operation
// [RL1] flags set only on status rising edge
// [RL2] warm: flag, charge on, lowered regulation voltage
// [RL3] hot: flag, pause charging and timer
// [RL4] conversion done sets flag, no response
// [RL5] three comparator alarm flags, no response
// [RL6] current ceiling flag, charging stays on
// [RL7] open thermistor: flag, pause charging, timer
// [RL8] watchdog expiry flag, charging stays on
// [RL9] timer expiry disables charge until toggle
// [RL10] restart timer only after flag cleared; code restarts on the toggle that ends the lockout, flag not checked
// [RL11] regulator overcurrent flag, regulator stays on
// [RL12] current pin open: charge off until reset
// [RL13] button low wake one time sets flag
// [RL14] button low wake two time sets flag
// [RL15] button low reset warning time sets flag
// [RL16] die overheat disables all, no flag
// [RL17] one fixed 128 us interrupt pulse
// [RL18] flags latched until host read clears
// [RL19] synchronised inputs, reset clears all latches
`timescale 1ns/1ps
module fault_flag_response #(
  parameter int unsigned WAKE_ONE_CYC   = fault_flag_pkg::WAKE_ONE_CYC,
  parameter int unsigned WAKE_TWO_CYC   = fault_flag_pkg::WAKE_TWO_CYC,
  parameter int unsigned RESET_WARN_CYC = fault_flag_pkg::RESET_WARN_CYC
) (
  input  wire logic        i_clk,            // 125 mhz clock
  input  wire logic        i_resetn,         // async reset, active low
  input  wire logic        i_psel,           // apb select
  input  wire logic        i_penable,        // apb enable
  input  wire logic        i_pwrite,         // apb write
  input  wire logic [7:0]  i_paddr,          // apb byte address
  input  wire logic [31:0] i_pwdata,         // apb write data
  output logic      [31:0] o_prdata,         // apb read data
  output logic             o_pready,         // apb ready
  output logic             o_pslverr,        // apb error
  input  wire logic [11:0] i_status,         // raw status, bits 0..11
  input  wire logic        i_push_button_n,  // push_button_input, low
  input  wire logic        i_input_supply,   // input_supply valid
  input  wire logic        i_charge_enable,  // charge enable input
  input  wire logic        i_die_overheat,   // die_overheat_shutdown
  output logic             o_irq_pulse,      // 128 us pulse to host
  output logic             o_irq,            // level, unmasked flags
  output logic             o_charge_en,      // charger enabled
  output logic             o_reduce_vreg,    // lowered regulation voltage
  output logic             o_timer_run,      // safety timer counting
  output logic             o_timer_clear,    // safety timer restart
  output logic             o_regulator_en,   // regulator output on
  output logic             o_rail_en         // system_rail path on
);

  localparam int unsigned FW = fault_flag_pkg::FLAG_WIDTH;
  localparam int unsigned PW = $clog2(fault_flag_pkg::IRQ_PULSE_CYC + 1);

  // three-stage synchronisers for all outside inputs except the apb bus
  logic [15:0] sync1_q, sync2_q, sync3_q;    // 12 status, button, vin, ce, ot
  logic [15:0] raw_in;                       // packed raw inputs
  assign raw_in = {i_die_overheat, i_charge_enable, i_input_supply,
                   ~i_push_button_n, i_status};

  // synchroniser chain; first stage feeds only the second
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1_q <= 16'h0000;
      sync2_q <= 16'h0000;
      sync3_q <= 16'h0000;
    end else begin
      sync1_q <= raw_in;  // RL19
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // debounced level: changes only when stage two and three agree
  logic [15:0] lvl_q;                        // accepted levels
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      lvl_q <= 16'h0000;
    end else begin
      for (int i = 0; i < 16; i++) begin
        if (sync2_q[i] == sync3_q[i]) begin
          lvl_q[i] <= sync3_q[i];  // RL19
        end
      end
    end
  end

  logic button_low;                          // button held low
  logic vin_lvl, ce_lvl, overheat;           // supply, enable, shutdown
  assign button_low = lvl_q[12];
  assign vin_lvl    = lvl_q[13];
  assign ce_lvl     = lvl_q[14];
  assign overheat   = lvl_q[15];

  // push-button hold counter, saturates at the longest time
  logic [31:0] hold_q;                       // cycles held low
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hold_q <= 32'h0000_0000;
    end else if (!button_low) begin
      hold_q <= 32'h0000_0000;
    end else if (hold_q < RESET_WARN_CYC) begin
      hold_q <= hold_q + 32'h0000_0001;
    end
  end

  // condition word: all fifteen status conditions
  logic [FW-1:0] cond;                       // live conditions
  assign cond = {hold_q >= RESET_WARN_CYC,   // RL15
                 hold_q >= WAKE_TWO_CYC,     // RL14
                 hold_q >= WAKE_ONE_CYC,     // RL13
                 lvl_q[11:0]};  // RL4 RL5 RL6 RL8

  // previous conditions for rising-edge detection
  logic [FW-1:0] cond_q;                     // delayed conditions
  logic [FW-1:0] rise;                       // rising edges
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cond_q <= '0;
    end else begin
      cond_q <= cond;
    end
  end
  assign rise = cond & ~cond_q;  // RL1

  // apb decode
  logic acc, wr, rd;                         // access phase strobes
  assign acc = i_psel & i_penable;
  assign wr  = acc & i_pwrite;
  assign rd  = acc & ~i_pwrite;

  // address match helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  logic flag_rd, flag_w1c;                   // flag read, flag w1c
  assign flag_rd  = rd & hit(i_paddr, fault_flag_pkg::OFS_FLAG);
  assign flag_w1c = wr & hit(i_paddr, fault_flag_pkg::OFS_FLAG);

  // latched flags: read clears, w1c clears, new edge wins
  logic [FW-1:0] flag_q;                     // sticky flags
  logic [FW-1:0] clr;                        // bits to clear
  assign clr = flag_rd ? {FW{1'b1}} :
               (flag_w1c ? i_pwdata[FW-1:0] : '0);
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      flag_q <= '0;
    end else begin
      flag_q <= (flag_q & ~clr) | rise;  // RL18
    end
  end

  // mask and control registers
  logic [FW-1:0] mask_q;                     // 1 passes the flag
  logic [1:0]    ctrl_q;                     // regulator/timer enables
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mask_q <= fault_flag_pkg::MASK_RST;
      ctrl_q <= fault_flag_pkg::CTRL_RST;
    end else if (wr) begin
      if (hit(i_paddr, fault_flag_pkg::OFS_MASK)) begin
        mask_q <= i_pwdata[FW-1:0];
      end
      if (hit(i_paddr, fault_flag_pkg::OFS_CTRL)) begin
        ctrl_q <= i_pwdata[1:0];  // RL11
      end
    end
  end

  // apb read data and answer, zero wait states
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_prdata  <= 32'h0000_0000;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= i_psel & ~i_penable;
      o_pslverr <= 1'b0;
      if (i_psel & ~i_penable) begin
        unique case (i_paddr)
          fault_flag_pkg::OFS_FLAG:
            o_prdata <= {17'h00000, flag_q | rise};
          fault_flag_pkg::OFS_MASK:   o_prdata <= {17'h00000, mask_q};
          fault_flag_pkg::OFS_STATUS: o_prdata <= {17'h00000, cond};
          fault_flag_pkg::OFS_CTRL:   o_prdata <= {30'h0, ctrl_q};
          default: begin
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // level interrupt from unmasked sticky flags
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(((flag_q & ~clr) | rise) & mask_q);
    end
  end

  // fixed-length host pulse on an unmasked new event while no pulse is running
  logic [PW-1:0] pulse_q;                    // remaining pulse cycles
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pulse_q     <= '0;
      o_irq_pulse <= 1'b0;
    end else begin
      if (pulse_q == '0 && |(rise & mask_q)) begin
        pulse_q <= PW'(fault_flag_pkg::IRQ_PULSE_CYC);  // RL17
      end else if (pulse_q != '0) begin
        pulse_q <= pulse_q - PW'(1);
      end
      o_irq_pulse <= (pulse_q > PW'(1)) ||
                     (pulse_q == '0 && |(rise & mask_q));
    end
  end

  // length of the pulse now high, watched by the pulse checks
  logic [PW-1:0] hi_cnt_q;                   // cycles pulse has been up
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hi_cnt_q <= '0;
    end else if (o_irq_pulse) begin
      hi_cnt_q <= hi_cnt_q + PW'(1);
    end else begin
      hi_cnt_q <= '0;
    end
  end

  // toggle detection on supply and charge enable
  logic vin_d_q, ce_d_q;                     // delayed levels
  logic toggle;                              // either one fell
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      vin_d_q <= 1'b0;
      ce_d_q  <= 1'b0;
    end else begin
      vin_d_q <= vin_lvl;
      ce_d_q  <= ce_lvl;
    end
  end
  assign toggle = (vin_d_q & ~vin_lvl) | (ce_d_q & ~ce_lvl);

  // safety timer lockout, cleared only by a toggle
  logic tmr_lock_q, tmr_restart_q;           // lockout, restart pending
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tmr_lock_q    <= 1'b0;
      tmr_restart_q <= 1'b0;
    end else begin
      if (rise[fault_flag_pkg::B_TIMER_EXP]) begin
        tmr_lock_q    <= 1'b1;  // RL9
        tmr_restart_q <= 1'b0;
      end else if (tmr_lock_q && toggle) begin
        tmr_lock_q    <= 1'b0;  // RL9
        tmr_restart_q <= 1'b1;  // RL10
      end else begin
        tmr_restart_q <= 1'b0;
      end
    end
  end

  // current pin open: latch until power-on reset
  logic pin_lock_q;                          // charge locked out
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_lock_q <= 1'b0;
    end else if (rise[fault_flag_pkg::B_PIN_OPEN]) begin
      pin_lock_q <= 1'b1;  // RL12
    end
  end

  // response outputs
  fault_flag_pkg::response_t rsp;            // next response
  always_comb begin
    logic pause;
    pause = cond[fault_flag_pkg::B_HOT] | cond[fault_flag_pkg::B_OPEN];
    // warm, ceiling, watchdog, alarms keep charging on  RL2 RL6 RL8 RL5
    rsp.charge_en    = ce_lvl & vin_lvl & ~pause & ~tmr_lock_q &
                       ~pin_lock_q & ~overheat;  // RL3
    rsp.reduce_vreg  = cond[fault_flag_pkg::B_WARM];  // RL2
    rsp.timer_run    = rsp.charge_en &
                       ctrl_q[fault_flag_pkg::C_TIMER_EN];  // RL7
    rsp.timer_clear  = tmr_restart_q;  // RL10
    rsp.regulator_en = ctrl_q[fault_flag_pkg::C_REG_EN] &
                       ~overheat;  // RL11
    rsp.rail_en      = ~overheat;  // RL16
  end

  // registered responses
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_charge_en    <= 1'b0;
      o_reduce_vreg  <= 1'b0;
      o_timer_run    <= 1'b0;
      o_timer_clear  <= 1'b0;
      o_regulator_en <= 1'b0;
      o_rail_en      <= 1'b0;
    end else begin
      o_charge_en    <= rsp.charge_en;
      o_reduce_vreg  <= rsp.reduce_vreg;
      o_timer_run    <= rsp.timer_run;
      o_timer_clear  <= rsp.timer_clear;
      o_regulator_en <= rsp.regulator_en;
      o_rail_en      <= rsp.rail_en;
    end
  end

  // assertions
  edge_only_a: assert property (  // RL1
    @(posedge i_clk) disable iff (!i_resetn)
    (!flag_q[0] && !$past(cond[0]) && !cond[0] && !flag_rd)
      |=> !flag_q[0]) else $error("flag set without edge");
  rise_flag_a: assert property (  // RL1
    @(posedge i_clk) disable iff (!i_resetn)
    (rise != '0) |=> ((flag_q & $past(rise)) == $past(rise)))
    else $error("edge did not set its flag");
  hot_pause_a: assert property (  // RL3
    @(posedge i_clk) disable iff (!i_resetn)
    cond[fault_flag_pkg::B_HOT] |=> !o_charge_en && !o_timer_run)
    else $error("hot did not pause");
  open_pause_a: assert property (  // RL7
    @(posedge i_clk) disable iff (!i_resetn)
    cond[fault_flag_pkg::B_OPEN] |=> !o_charge_en && !o_timer_run)
    else $error("open did not pause");
  warm_vreg_a: assert property (  // RL2
    @(posedge i_clk) disable iff (!i_resetn)
    cond[fault_flag_pkg::B_WARM] |=> o_reduce_vreg)
    else $error("warm did not lower voltage");
  timer_lock_a: assert property (  // RL9
    @(posedge i_clk) disable iff (!i_resetn)
    rise[fault_flag_pkg::B_TIMER_EXP] |=> ##1 !o_charge_en)
    else $error("expiry did not stop charge");
  restart_gate_a: assert property (  // RL10
    @(posedge i_clk) disable iff (!i_resetn)
    tmr_restart_q |-> !tmr_lock_q)
    else $error("timer restarted while locked");
  reg_keep_a: assert property (  // RL11
    @(posedge i_clk) disable iff (!i_resetn)
    (cond[fault_flag_pkg::B_REG_OCP] && ctrl_q[fault_flag_pkg::C_REG_EN] &&
     !overheat) |=> o_regulator_en)
    else $error("overcurrent turned regulator off");
  pin_latch_a: assert property (  // RL12
    @(posedge i_clk) disable iff (!i_resetn)
    rise[fault_flag_pkg::B_PIN_OPEN] |=> pin_lock_q)
    else $error("pin open did not latch");
  pin_lock_a: assert property (  // RL12
    @(posedge i_clk) disable iff (!i_resetn)
    pin_lock_q |=> !o_charge_en) else $error("pin lockout lost");
  overheat_off_a: assert property (  // RL16
    @(posedge i_clk) disable iff (!i_resetn)
    overheat |=> !o_rail_en && !o_regulator_en && !o_charge_en &&
     !o_timer_run) else $error("overheat left outputs on");
  pulse_len_a: assert property (  // RL17
    @(posedge i_clk) disable iff (!i_resetn)
    $rose(o_irq_pulse) |-> o_irq_pulse [*8])
    else $error("interrupt pulse too short");
  pulse_full_a: assert property (  // RL17
    @(posedge i_clk) disable iff (!i_resetn)
    (o_irq_pulse && hi_cnt_q < PW'(fault_flag_pkg::IRQ_PULSE_CYC - 1))
      |=> o_irq_pulse) else $error("interrupt pulse cut short");
  pulse_max_a: assert property (  // RL17
    @(posedge i_clk) disable iff (!i_resetn)
    hi_cnt_q <= PW'(fault_flag_pkg::IRQ_PULSE_CYC))
    else $error("interrupt pulse too long");
  flag_hold_a: assert property (  // RL18
    @(posedge i_clk) disable iff (!i_resetn)
    (flag_q[1] && !acc) |=> flag_q[1])
    else $error("flag lost without read");
  read_clear_a: assert property (  // RL18
    @(posedge i_clk) disable iff (!i_resetn)
    flag_rd |=> (flag_q == $past(rise)))
    else $error("read did not clear flags");
  irq_level_a: assert property (  // RL18
    @(posedge i_clk) disable iff (!i_resetn)
    ((flag_q & mask_q) != '0 && !acc) |=> o_irq)
    else $error("interrupt level missing");

endmodule : fault_flag_response

/* File: testbench/fault_flag_response_tb_top.sv */
/*
  testbench for the fault flag block: each scenario drives inputs or registers
  inputs and judges responses. assumes host_model as the apb master.
*/
`timescale 1ns/1ps
module fault_flag_response_tb_top;
  logic                     i_clk, i_resetn;       // clock, reset
  logic [11:0]              status;                // raw conditions
  logic                     btn_n, supply, chg_en; // button, supply, enable
  logic                     die;                   // die overheat
  fault_flag_pkg::apb_req_t req;                   // apb request
  logic [31:0]              prdata, d;             // read data
  logic                     pready, pslverr, e;    // apb answer
  logic                     irq_pulse, irq;        // interrupts
  logic                     charge_en, reduce_vreg, timer_run;
  logic                     timer_clear, regulator_en, rail_en;
  int                       fails, checks_done, cycles, clears;

  fault_flag_response #(.WAKE_ONE_CYC(10), .WAKE_TWO_CYC(20),
    .RESET_WARN_CYC(30)) i_fault_flag_response (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_psel(req.psel),
    .i_penable(req.penable), .i_pwrite(req.pwrite), .i_paddr(req.paddr),
    .i_pwdata(req.pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_status(status), .i_push_button_n(btn_n),
    .i_input_supply(supply), .i_charge_enable(chg_en),
    .i_die_overheat(die), .o_irq_pulse(irq_pulse), .o_irq(irq),
    .o_charge_en(charge_en), .o_reduce_vreg(reduce_vreg),
    .o_timer_run(timer_run), .o_timer_clear(timer_clear),
    .o_regulator_en(regulator_en), .o_rail_en(rail_en));

  host_model i_host_model (.i_clk(i_clk), .o_req(req), .i_prdata(prdata),
    .i_pready(pready), .i_pslverr(pslverr), .i_irq_pulse(irq_pulse));

  // free running clock
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // timer restart pulses, and the cycle ceiling
  always @(posedge i_clk) begin
    if (timer_clear === 1'b1) clears++;
    cycles++;
    if (cycles == 40000) begin
      fails++;
      test_done();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic settle();
    repeat (8) @(posedge i_clk);
  endtask : settle

  task automatic rd(input logic [7:0] a);
    i_host_model.xfer(1'b0, a, 32'h0, d, e);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    i_host_model.xfer(1'b1, a, v, d, e);
  endtask : wr

  // reset values, unmapped access, timer enabled
  task automatic t_reset();
    rd(fault_flag_pkg::OFS_MASK);
    chk("mask reset", 32'h7fff, d);
    rd(fault_flag_pkg::OFS_CTRL);
    chk("ctrl reset", 32'h1, d);
    rd(fault_flag_pkg::OFS_FLAG);
    chk("flags reset", 32'h0, d);
    rd(8'h10);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("rail on", 32'h1, {31'h0, rail_en});
    wr(fault_flag_pkg::OFS_CTRL, 32'h3);
    settle();
    chk("charge on", 32'h1, {31'h0, charge_en});
    chk("timer on", 32'h1, {31'h0, timer_run});
  endtask : t_reset

  // one pulse on a rising edge, read clears, masked edge is quiet
  task automatic t_irq();
    status[2] <= 1'b1;
    settle();
    chk("irq level", 32'h1, {31'h0, irq});
    chk("conv charge", 32'h1, {31'h0, charge_en});
    repeat (16100) @(posedge i_clk);
    chk("pulse len", fault_flag_pkg::IRQ_PULSE_CYC,
        i_host_model.pulse_len);
    rd(fault_flag_pkg::OFS_FLAG);
    chk("conv flag", 32'h4, d);
    rd(fault_flag_pkg::OFS_FLAG);
    chk("flag cleared", 32'h0, d);
    chk("irq off", 32'h0, {31'h0, irq});
    wr(fault_flag_pkg::OFS_MASK, 32'h0);
    status[2] <= 1'b0;
    settle();
    status[2] <= 1'b1;
    settle();
    chk("masked irq", 32'h0, {31'h0, irq});
    chk("pulse count", 32'h1, i_host_model.pulse_cnt);
    rd(fault_flag_pkg::OFS_FLAG);
    chk("masked flag", 32'h4, d);
  endtask : t_irq

  // events that flag without touching the charger
  task automatic t_events();
    int ev[5] = '{3, 4, 5, 6, 8};
    foreach (ev[i]) begin
      status[ev[i]] <= 1'b1;
      settle();
      chk("event charge", 32'h1, {31'h0, charge_en});
      rd(fault_flag_pkg::OFS_FLAG);
      chk("event flag", 32'h1 << ev[i], d);
      rd(fault_flag_pkg::OFS_STATUS);
      chk("event status", (32'h1 << ev[i]) | 32'h4, d);
      status[ev[i]] <= 1'b0;
    end
  endtask : t_events

  // warm lowers regulation; hot and open pause charge and timer
  task automatic t_therm();
    int ev[2] = '{1, 7};
    status[0] <= 1'b1;
    settle();
    chk("warm vreg", 32'h1, {31'h0, reduce_vreg});
    chk("warm charge", 32'h1, {31'h0, charge_en});
    chk("warm timer", 32'h1, {31'h0, timer_run});
    status[0] <= 1'b0;
    foreach (ev[i]) begin
      status[ev[i]] <= 1'b1;
      settle();
      chk("pause charge", 32'h0, {31'h0, charge_en});
      chk("pause timer", 32'h0, {31'h0, timer_run});
      status[ev[i]] <= 1'b0;
      settle();
      chk("resume charge", 32'h1, {31'h0, charge_en});
    end
  endtask : t_therm

  // timer expiry locks charge until a charge enable toggle
  task automatic t_timer();
    int c0;
    c0 = clears;
    status[9] <= 1'b1;
    settle();
    status[9] <= 1'b0;
    settle();
    chk("lockout", 32'h0, {31'h0, charge_en});
    chk("no restart", 32'h0, clears - c0);
    chg_en <= 1'b0;
    settle();
    chg_en <= 1'b1;
    settle();
    chk("unlocked", 32'h1, {31'h0, charge_en});
    chk("restart", 32'h1, clears - c0);
  endtask : t_timer

  // regulator overcurrent leaves the regulator on until the host acts
  task automatic t_regocp();
    status[10] <= 1'b1;
    settle();
    chk("ocp reg on", 32'h1, {31'h0, regulator_en});
    wr(fault_flag_pkg::OFS_CTRL, 32'h2);
    settle();
    chk("host reg off", 32'h0, {31'h0, regulator_en});
    wr(fault_flag_pkg::OFS_CTRL, 32'h3);
    status[10] <= 1'b0;
  endtask : t_regocp

  // short press sets nothing, long press sets all three hold flags
  task automatic t_button();
    rd(fault_flag_pkg::OFS_FLAG);
    btn_n <= 1'b0;
    repeat (8) @(posedge i_clk);
    btn_n <= 1'b1;
    settle();
    rd(fault_flag_pkg::OFS_FLAG);
    chk("short press", 32'h0, {29'h0, d[14:12]});
    btn_n <= 1'b0;
    repeat (45) @(posedge i_clk);
    btn_n <= 1'b1;
    settle();
    rd(fault_flag_pkg::OFS_FLAG);
    chk("long press", 32'h7, {29'h0, d[14:12]});
  endtask : t_button

  // die overheat shuts everything off and flags nothing
  task automatic t_heat();
    rd(fault_flag_pkg::OFS_FLAG);
    die <= 1'b1;
    settle();
    chk("heat outputs", 32'h0,
        {charge_en, timer_run, regulator_en, rail_en});
    rd(fault_flag_pkg::OFS_FLAG);
    chk("heat flags", 32'h0, d);
    die <= 1'b0;
  endtask : t_heat

  // current pin open locks charge until a reset clears it
  task automatic t_pin();
    status[11] <= 1'b1;
    settle();
    rd(fault_flag_pkg::OFS_FLAG);
    chk("pin flag", 32'h800, d);
    status[11] <= 1'b0;
    settle();
    chk("pin lock", 32'h0, {31'h0, charge_en});
    i_resetn <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_resetn <= 1'b1;
    settle();
    chk("reset unlock", 32'h1, {31'h0, charge_en});
  endtask : t_pin

  task automatic test_done();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done

  // main sequence
  initial begin
    i_resetn = 1'b0;
    status   = '0;
    btn_n    = 1'b1;
    supply   = 1'b1;
    chg_en   = 1'b1;
    die      = 1'b0;
    repeat (20) @(posedge i_clk);
    i_resetn <= 1'b1;
    t_reset();
    t_irq();
    t_events();
    t_therm();
    t_timer();
    t_regocp();
    t_button();
    t_heat();
    t_pin();
    test_done();
  end
endmodule : fault_flag_response_tb_top

/* File: testbench/host_model.sv */
/*
  host model: apb master that reads and clears the flags and times
  the interrupt pulse. assumes the fault flag block as its apb slave.
*/
`timescale 1ns/1ps
module host_model (
  input  wire logic                i_clk,       // block clock
  output fault_flag_pkg::apb_req_t o_req,       // apb request
  input  wire logic [31:0]         i_prdata,    // read data
  input  wire logic                i_pready,    // ready
  input  wire logic                i_pslverr,   // slave error
  input  wire logic                i_irq_pulse  // interrupt pulse
);
  int pulse_len;  // length of the last pulse
  int pulse_cnt;  // pulses seen
  int run_len;    // length of the pulse now high

  initial o_req = '0;

  // time each interrupt pulse in clock cycles
  always @(posedge i_clk) begin
    if (i_irq_pulse === 1'b1) run_len <= run_len + 1;
    else if (run_len != 0) begin
      pulse_len <= run_len;
      pulse_cnt <= pulse_cnt + 1;
      run_len   <= 0;
    end
  end

  // one transfer: setup, then access held until ready is sampled
  task automatic xfer(input logic wr, input logic [7:0] addr,
                      input logic [31:0] wdata, output logic [31:0] rdata,
                      output logic err);
    @(posedge i_clk);
    o_req <= '{1'b1, 1'b0, wr, addr, wdata};
    @(posedge i_clk);
    o_req.penable <= 1'b1;
    do begin
      @(posedge i_clk);
    end while (i_pready !== 1'b1);
    rdata = i_prdata;
    err   = i_pslverr;
    // released lines show the inverse, not the last value
    o_req <= '{1'b0, 1'b0, ~wr, ~addr, ~wdata};
  endtask : xfer
endmodule : host_model
